//--- inc/rssm_pkg.sv
// Package with register map, field positions and timing for the reset sequencer.
package rssm_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_RST_SRC = 4'h0;
  localparam logic [3:0] ADDR_MON_CTRL = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
  localparam int ADDR_W = 4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_POR_FLAG = 1;
  localparam int BIT_SWRST = 4;
  localparam int BIT_MON_EN = 7;
  localparam int BIT_MON_STAT = 6;
  localparam int BIT_EV_POR = 0;
  localparam int BIT_EV_SUPPLY = 1;
  localparam int EV_W = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [3:0] WDT_DIV = 4'hC;
  localparam logic CLK_SEL_INTOSC = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int RELEASE_DELAY_US = 300;
  localparam int RELEASE_DELAY_CYC = RELEASE_DELAY_US * (CLK_HZ / 1_000_000);

  typedef enum logic [1:0] {
    RSSM_POR,
    RSSM_DELAY,
    RSSM_SUPPLY,
    RSSM_RUN
  } rssm_state_t;

endpackage

//--- logic/rssm_reset_sequencer.sv
// Reset sequencer with supply monitor, reset pin driver and cause flags.
// Operation
// RULE1: Hold core, clear registers, block interrupts during reset.
// RULE2: Keep data memory; restore stack pointer.
// RULE3: Port latches all ones, pull-ups stay on.
// RULE4: Drive reset pin low for power/supply resets.
// RULE5: Clock selection returns to internal oscillator.
// RULE6: Watchdog on, clocked by system clock over twelve.
// RULE7: Program counter cleared, start at zero.
// RULE8: Power-up waits threshold, then release delay.
// RULE9: Power-on flag set after power or supply reset.
// RULE10: Other resets clear flag; causes then undefined.
// RULE11: Power-on reset enables the supply monitor.
// RULE12: Only power-on changes monitor enable state.
// RULE13: Supply below threshold enters reset, leaves above.
// RULE14: Software enables monitor before selecting it.
// RULE15: Writing one at flag position selects monitor.
// RULE16: No release delay after supply-monitor reset.
// RULE17: Monitor resets only if enabled and selected.
// RULE18: Synchronize inputs; assert fast, release synchronously.
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module rssm_reset_sequencer #(
  parameter int RELEASE_CYC = rssm_pkg::RELEASE_DELAY_CYC
) (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  // Analog detectors and soft reset request
  input wire logic powerOnDetect,
  input wire logic supplyBelow,
  input wire logic softResetReq,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // Reset pin, open drain
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  // Core reset state and interrupt
  output logic coreReset,
  output logic [15:0] pcInit,
  output logic [7:0] spInit,
  output logic [7:0] portLatchInit,
  output logic pullupEn,
  output logic clkSel,
  output logic wdtEn,
  output logic [3:0] wdtDiv,
  output logic irqTimerBlock,
  output logic irq
);

  // ----------------------------------------------------------------
  // Synchronizers
  // ----------------------------------------------------------------
  logic porSync1_reg, porSync2_reg, lowSync1_reg, lowSync2_reg;
  always_ff @(posedge clk_sys) begin
    if (clkEn) begin
      porSync1_reg <= powerOnDetect; // RULE18
      porSync2_reg <= porSync1_reg;
      lowSync1_reg <= supplyBelow; // RULE18
      lowSync2_reg <= lowSync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  rssm_pkg::rssm_state_t state_reg;
  logic monEn_reg, monSel_reg, porFlag_reg, swFlag_reg;
  logic [rssm_pkg::EV_W-1:0] stat_reg, mask_reg;
  logic [31:0] cnt_reg;
  logic supplyTrip, wbReq, wbWr, wbRd, lowNow;

  assign lowNow = lowSync2_reg;
  assign supplyTrip = lowNow && monEn_reg && monSel_reg; // RULE17
  assign wbReq = wbCyc && wbStb && !wbAck;
  assign wbWr = wbReq && wbWe && wbSel[0];
  assign wbRd = wbReq && !wbWe;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || porSync2_reg) begin
      state_reg <= rssm_pkg::RSSM_POR;
      cnt_reg <= '0;
    end else if (clkEn) begin
      unique case (state_reg)
        rssm_pkg::RSSM_POR: begin
          cnt_reg <= '0;
          if (!lowNow) begin
            state_reg <= rssm_pkg::RSSM_DELAY; // RULE8
          end
        end
        rssm_pkg::RSSM_DELAY: begin
          if (lowNow) begin
            state_reg <= rssm_pkg::RSSM_POR;
          end else if (cnt_reg >= 32'(RELEASE_CYC - 1)) begin
            state_reg <= rssm_pkg::RSSM_RUN; // RULE8
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        rssm_pkg::RSSM_SUPPLY: begin
          if (!lowNow) begin
            state_reg <= rssm_pkg::RSSM_RUN; // RULE13 RULE16
          end
        end
        rssm_pkg::RSSM_RUN: begin
          if (supplyTrip) begin
            state_reg <= rssm_pkg::RSSM_SUPPLY; // RULE13
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Monitor enable, selection and cause flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || porSync2_reg) begin
      monEn_reg <= 1'b1; // RULE11
      monSel_reg <= 1'b0;
      porFlag_reg <= 1'b1; // RULE9
      swFlag_reg <= 1'b0;
    end else if (clkEn) begin
      if (softResetReq) begin
        porFlag_reg <= 1'b0; // RULE10 RULE12
        swFlag_reg <= 1'b1;
        monSel_reg <= 1'b0;
      end else if (state_reg == rssm_pkg::RSSM_SUPPLY) begin
        porFlag_reg <= 1'b1; // RULE9
        swFlag_reg <= 1'b0;
      end else if (wbWr && wbAdr == rssm_pkg::ADDR_RST_SRC) begin
        monSel_reg <= wbDatW[rssm_pkg::BIT_POR_FLAG]; // RULE15 RULE14
      end
      if (!softResetReq && wbWr && wbAdr == rssm_pkg::ADDR_MON_CTRL) begin
        monEn_reg <= wbDatW[rssm_pkg::BIT_MON_EN]; // RULE12
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, set wins over read clear
  // ----------------------------------------------------------------
  logic [rssm_pkg::EV_W-1:0] evSet, statNext, maskNext;
  logic inRunPrev_reg;
  always_comb begin
    evSet = '0;
    evSet[rssm_pkg::BIT_EV_POR] = state_reg == rssm_pkg::RSSM_RUN
      && !inRunPrev_reg && porFlag_reg;
    evSet[rssm_pkg::BIT_EV_SUPPLY] = supplyTrip
      && state_reg == rssm_pkg::RSSM_RUN;
  end
  // The interrupt follows the values that the registers are about to take.
  always_comb begin
    statNext = stat_reg | evSet;
    maskNext = mask_reg;
    if (wbRd && wbAdr == rssm_pkg::ADDR_IRQ_STAT) begin
      statNext = evSet;
    end
    if (wbWr && wbAdr == rssm_pkg::ADDR_IRQ_MASK) begin
      maskNext = wbDatW[rssm_pkg::EV_W-1:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat_reg <= '0;
      mask_reg <= '0;
      inRunPrev_reg <= 1'b0;
      irq <= 1'b0;
    end else if (clkEn) begin
      inRunPrev_reg <= state_reg == rssm_pkg::RSSM_RUN;
      if (wbRd && wbAdr == rssm_pkg::ADDR_IRQ_STAT) begin
        stat_reg <= evSet;
      end else begin
        stat_reg <= stat_reg | evSet;
      end
      if (wbWr && wbAdr == rssm_pkg::ADDR_IRQ_MASK) begin
        mask_reg <= wbDatW[rssm_pkg::EV_W-1:0];
      end
      irq <= |(statNext & maskNext);
    end
  end

  // ----------------------------------------------------------------
  // Wishbone read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wbAck <= 1'b0;
      wbDatR <= '0;
    end else if (clkEn) begin
      wbAck <= wbReq;
      wbDatR <= '0;
      if (wbRd) begin
        unique case (wbAdr)
          rssm_pkg::ADDR_RST_SRC: begin
            wbDatR[rssm_pkg::BIT_POR_FLAG] <= porFlag_reg;
            wbDatR[rssm_pkg::BIT_SWRST] <= swFlag_reg; // RULE10
          end
          rssm_pkg::ADDR_MON_CTRL: begin
            wbDatR[rssm_pkg::BIT_MON_EN] <= monEn_reg;
            wbDatR[rssm_pkg::BIT_MON_STAT] <= !lowNow;
          end
          rssm_pkg::ADDR_IRQ_STAT: begin
            wbDatR[rssm_pkg::EV_W-1:0] <= stat_reg;
          end
          rssm_pkg::ADDR_IRQ_MASK: begin
            wbDatR[rssm_pkg::EV_W-1:0] <= mask_reg;
          end
          default: begin
            wbDatR <= '0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Core reset outputs
  // ----------------------------------------------------------------
  logic inReset;
  assign inReset = rst || porSync2_reg || softResetReq
    || state_reg != rssm_pkg::RSSM_RUN;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      coreReset <= 1'b1;
      resetPinOut <= 1'b0;
      resetPinOe <= 1'b1;
      irqTimerBlock <= 1'b1;
    end else if (clkEn) begin
      coreReset <= inReset; // RULE1
      irqTimerBlock <= inReset; // RULE1
      resetPinOut <= 1'b0;
      resetPinOe <= porSync2_reg || (state_reg != rssm_pkg::RSSM_RUN); // RULE4
    end
  end

  // Constant reset-exit values, loaded by the core while coreReset is high.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pcInit <= rssm_pkg::PC_RST; // RULE7
      spInit <= rssm_pkg::SP_RST; // RULE2
      portLatchInit <= rssm_pkg::PORT_LATCH_RST; // RULE3
      pullupEn <= 1'b1; // RULE3
      clkSel <= rssm_pkg::CLK_SEL_INTOSC; // RULE5
      wdtEn <= 1'b1; // RULE6
      wdtDiv <= rssm_pkg::WDT_DIV; // RULE6
    end else if (clkEn && inReset) begin
      pcInit <= rssm_pkg::PC_RST;
      spInit <= rssm_pkg::SP_RST;
      portLatchInit <= rssm_pkg::PORT_LATCH_RST;
      pullupEn <= 1'b1;
      clkSel <= rssm_pkg::CLK_SEL_INTOSC;
      wdtEn <= 1'b1;
      wdtDiv <= rssm_pkg::WDT_DIV;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_trip;
    @(posedge clk_sys) disable iff (rst || !clkEn)
    (state_reg == rssm_pkg::RSSM_RUN && supplyTrip && !porSync2_reg)
      |=> state_reg == rssm_pkg::RSSM_SUPPLY;
  endproperty
  a_trip: assert property (p_trip) else $error("supply trip missed"); // RULE13
  property p_nosel;
    @(posedge clk_sys) disable iff (rst || !clkEn)
    (state_reg == rssm_pkg::RSSM_RUN && !monSel_reg && !porSync2_reg)
      |=> state_reg == rssm_pkg::RSSM_RUN;
  endproperty
  a_nosel: assert property (p_nosel) else $error("unselected reset"); // RULE17
  property p_pin;
    @(posedge clk_sys) disable iff (rst || !clkEn)
    (state_reg != rssm_pkg::RSSM_RUN) |=> resetPinOe && !resetPinOut;
  endproperty
  a_pin: assert property (p_pin) else $error("reset pin not low"); // RULE4
  property p_core;
    @(posedge clk_sys) disable iff (rst || !clkEn)
    (state_reg != rssm_pkg::RSSM_RUN) |=> coreReset && irqTimerBlock;
  endproperty
  a_core: assert property (p_core) else $error("core not held"); // RULE1
  property p_noDelay;
    @(posedge clk_sys) disable iff (rst || !clkEn || porSync2_reg)
    (state_reg == rssm_pkg::RSSM_SUPPLY && !lowNow)
      |=> state_reg == rssm_pkg::RSSM_RUN;
  endproperty
  a_noDelay: assert property (p_noDelay) else $error("delay added"); // RULE16
  property p_delay;
    @(posedge clk_sys) disable iff (rst || !clkEn || porSync2_reg)
    (state_reg == rssm_pkg::RSSM_DELAY && $past(state_reg)
      == rssm_pkg::RSSM_POR) |=> state_reg != rssm_pkg::RSSM_RUN;
  endproperty
  a_delay: assert property (p_delay) else $error("delay skipped"); // RULE8
  property p_flag;
    @(posedge clk_sys) disable iff (rst || !clkEn || softResetReq)
    (state_reg == rssm_pkg::RSSM_SUPPLY) |=> porFlag_reg;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set"); // RULE9
  property p_porEn;
    @(posedge clk_sys) disable iff (rst || !clkEn)
    porSync2_reg |=> monEn_reg && porFlag_reg;
  endproperty
  a_porEn: assert property (p_porEn) else $error("monitor off"); // RULE11
  property p_swKeep;
    @(posedge clk_sys) disable iff (rst || !clkEn || porSync2_reg)
    softResetReq |=> monEn_reg == $past(monEn_reg) && !porFlag_reg;
  endproperty
  a_swKeep: assert property (p_swKeep) else $error("soft reset leak"); // RULE12
  property p_wdt;
    @(posedge clk_sys) disable iff (rst || !clkEn)
    coreReset |-> wdtEn && wdtDiv == rssm_pkg::WDT_DIV
      && pcInit == rssm_pkg::PC_RST;
  endproperty
  a_wdt: assert property (p_wdt) else $error("exit state wrong"); // RULE6
  property p_pinOut;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |-> !resetPinOut;
  endproperty
  a_pinOut: assert property (p_pinOut) else $error("pin driven high"); // RULE4
  property p_irq;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |-> irq == |(stat_reg & mask_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong"); // RULE9
  property p_port;
    @(posedge clk_sys) disable iff (rst || !clkEn)
    coreReset |-> portLatchInit == rssm_pkg::PORT_LATCH_RST && pullupEn
      && spInit == rssm_pkg::SP_RST;
  endproperty
  a_port: assert property (p_port) else $error("port state wrong"); // RULE3
  property p_clkSel;
    @(posedge clk_sys) disable iff (rst || !clkEn)
    coreReset |-> clkSel == rssm_pkg::CLK_SEL_INTOSC;
  endproperty
  a_clkSel: assert property (p_clkSel) else $error("clock not internal"); // RULE5
  property p_pc;
    @(posedge clk_sys) disable iff (rst || !clkEn)
    coreReset |-> pcInit == rssm_pkg::PC_RST;
  endproperty
  a_pc: assert property (p_pc) else $error("start address wrong"); // RULE7
  property p_hold;
    @(posedge clk_sys) disable iff (rst || !clkEn || porSync2_reg)
    (state_reg == rssm_pkg::RSSM_SUPPLY && lowNow)
      |=> state_reg != rssm_pkg::RSSM_RUN;
  endproperty
  a_hold: assert property (p_hold) else $error("left reset early"); // RULE13
  property p_swFlag;
    @(posedge clk_sys) disable iff (rst || !clkEn || porSync2_reg)
    softResetReq |=> swFlag_reg && !monSel_reg;
  endproperty
  a_swFlag: assert property (p_swFlag) else $error("soft flag wrong"); // RULE10
  property p_sel;
    @(posedge clk_sys) disable iff (rst || !clkEn || porSync2_reg)
    (wbWr && wbAdr == rssm_pkg::ADDR_RST_SRC && !softResetReq
      && state_reg != rssm_pkg::RSSM_SUPPLY
      && wbDatW[rssm_pkg::BIT_POR_FLAG]) |=> monSel_reg;
  endproperty
  a_sel: assert property (p_sel) else $error("monitor not selected"); // RULE15

  c_trip: cover property (@(posedge clk_sys)
    state_reg == rssm_pkg::RSSM_SUPPLY);
  c_run: cover property (@(posedge clk_sys)
    state_reg == rssm_pkg::RSSM_RUN && porFlag_reg);
  c_irq: cover property (@(posedge clk_sys) irq);
  c_soft: cover property (@(posedge clk_sys)
    softResetReq && !monEn_reg);

endmodule
`default_nettype wire

//--- tb/rssm_supply_model.sv
// Model of the power-on detector, supply comparator and reset pin.
`timescale 1ns/1ns
`default_nettype none
module rssm_supply_model (
  // Clock
  input wire logic clk_sys,
  // Commands from the bench
  input wire logic porCmd,
  input wire logic dipCmd,
  // Reset pin, open drain with pull-up
  input wire logic resetPinOe,
  output wire logic resetPinIn,
  // Detector outputs
  output logic powerOnDetect,
  output logic supplyBelow
);
  initial begin
    powerOnDetect = 1'b0;
    supplyBelow = 1'b0;
  end
  // Detector outputs move only just after a clock edge.
  always @(posedge clk_sys) begin
    powerOnDetect <= porCmd;
    supplyBelow <= dipCmd;
  end
  // The pull-up wins whenever nobody pulls the pin low.
  assign resetPinIn = resetPinOe ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

//--- tb/test_rssm_reset_sequencer.sv
// Self-checking bench for the reset sequencer.
`timescale 1ns/1ns
`default_nettype none
module test_rssm_reset_sequencer;
  typedef struct packed {
    logic w;
    logic [3:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
  } rssm_row_t;
  logic clk_sys = 0, rst = 1, clkEn = 1, softResetReq = 0;
  logic porCmd = 0, dipCmd = 0, powerOnDetect, supplyBelow;
  logic wbCyc = 0, wbStb = 0, wbWe = 0, wbAck, irq;
  logic [3:0] wbAdr = 4'h0, wbSel = 4'hF, wdtDiv;
  logic [31:0] wbDatW = 32'h0, wbDatR, q;
  logic resetPinIn, resetPinOut, resetPinOe, coreReset, pullupEn, clkSel;
  logic wdtEn, irqTimerBlock;
  logic [15:0] pcInit;
  logic [7:0] spInit, portLatchInit;
  int mismatches = 0, samples_checked = 0, cyc = 0, n;
  rssm_row_t rows [0:7] = '{
    '{1'b0, 4'h0, 32'h0, 32'h12, 32'h2}, '{1'b0, 4'h4, 32'h0, 32'hC0, 32'hC0},
    '{1'b0, 4'h8, 32'h0, 32'h1, 32'h1}, '{1'b0, 4'h8, 32'h0, 32'h3, 32'h0},
    '{1'b1, 4'hC, 32'h3, 32'h0, 32'h0}, '{1'b0, 4'hC, 32'h0, 32'h3, 32'h3},
    '{1'b1, 4'h2, 32'hFF, 32'h0, 32'h0}, '{1'b0, 4'h2, 32'h0, 32'hFFFFFFFF, 32'h0}};

  always #4 clk_sys = ~clk_sys;

  rssm_supply_model model (.clk_sys(clk_sys), .porCmd(porCmd),
    .dipCmd(dipCmd), .resetPinOe(resetPinOe), .resetPinIn(resetPinIn),
    .powerOnDetect(powerOnDetect), .supplyBelow(supplyBelow));

  rssm_reset_sequencer #(.RELEASE_CYC(10)) uut (.clk_sys(clk_sys),
    .rst(rst), .clkEn(clkEn), .powerOnDetect(powerOnDetect),
    .supplyBelow(supplyBelow), .softResetReq(softResetReq), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
    .resetPinIn(resetPinIn), .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe), .coreReset(coreReset), .pcInit(pcInit),
    .spInit(spInit), .portLatchInit(portLatchInit), .pullupEn(pullupEn),
    .clkSel(clkSel), .wdtEn(wdtEn), .wdtDiv(wdtDiv),
    .irqTimerBlock(irqTimerBlock), .irq(irq));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One classic cycle; ack is sampled at the rising edge it was raised for.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatW <= d;
    @(posedge clk_sys);
    while (wbAck !== 1'b1 && cyc < 3000) @(posedge clk_sys);
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic waitCore(input logic v, input int lim);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (coreReset !== v && n < lim);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk({coreReset, resetPinOe, irqTimerBlock}, 32'h7);
    waitCore(1'b0, 40);
    chk(32'(n >= 10 && n <= 16), 32'h1);
    chk({pcInit, spInit, portLatchInit}, 32'h000007FF);
    chk({pullupEn, clkSel, wdtEn, wdtDiv}, 32'h5C);
    $display("test power-up done");
    foreach (rows[i]) begin
      wb(rows[i].w, rows[i].a, rows[i].d);
      chk(q & rows[i].m, rows[i].e);
    end
    $display("test register table done");
    dipCmd <= 1'b1;
    tick(8);
    chk({31'h0, coreReset}, 32'h0);
    dipCmd <= 1'b0;
    tick(4);
    wb(1'b1, 4'h0, 32'h2);
    dipCmd <= 1'b1;
    waitCore(1'b1, 8);
    chk({coreReset, resetPinOe, resetPinIn}, 32'h6);
    tick(5);
    dipCmd <= 1'b0;
    waitCore(1'b0, 8);
    chk(32'(n <= 6), 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h1);
    wb(1'b0, 4'h0, 32'h0);
    chk(q & 32'h2, 32'h2);
    wb(1'b0, 4'h8, 32'h0);
    chk(q & 32'h2, 32'h2);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    $display("test supply trip done");
    wb(1'b1, 4'h4, 32'h0);
    wb(1'b1, 4'hC, 32'h0);
    softResetReq <= 1'b1;
    tick(3);
    softResetReq <= 1'b0;
    waitCore(1'b0, 40);
    wb(1'b0, 4'h0, 32'h0);
    chk(q & 32'h2, 32'h0);
    wb(1'b0, 4'h4, 32'h0);
    chk(q & 32'h80, 32'h0);
    dipCmd <= 1'b1;
    tick(8);
    chk({31'h0, coreReset}, 32'h0);
    dipCmd <= 1'b0;
    $display("test soft reset done");
    porCmd <= 1'b1;
    waitCore(1'b1, 8);
    chk({coreReset, resetPinOe}, 32'h3);
    porCmd <= 1'b0;
    waitCore(1'b0, 40);
    chk(32'(n >= 10), 32'h1);
    wb(1'b0, 4'h4, 32'h0);
    chk(q & 32'h80, 32'h80);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, 4'hC, 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h1);
    wb(1'b0, 4'h8, 32'h0);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    $display("test power-on event done");
    complete_run();
  end
endmodule
`default_nettype wire
